// ### core/sps_pkg.sv
// Package for the start-up configuration register bank.
// Assumes one 50 MHz system clock; the serial pins are synchronous to it.
package sps_pkg;

  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_FRAME = 5'h10;
  localparam logic [CNT_W-1:0] CNT_LAST_CMD_BIT = 5'h07;
  localparam logic [CNT_W-1:0] CNT_FIRST_DATA = 5'h08;
  localparam int CMD_HI = 15;
  localparam int CMD_LO = 14;
  localparam int ADDR_HI = 13;
  localparam int ADDR_LO = 9;
  localparam int PARITY_BIT = 8;
  localparam int DATA_HI = 7;
  localparam logic [1:0] CMD_WRITE = 2'h1;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [4:0] ADDR_SUPPLY_SETUP = 5'h05;
  localparam logic [4:0] ADDR_WATCHDOG_SETUP = 5'h06;
  localparam logic [7:0] SUPPLY_SETUP_RST = 8'h80;
  localparam logic [7:0] WATCHDOG_SETUP_RST = 8'h42;

  // ****************************************************************
  // Field codes
  // ****************************************************************
  localparam logic [1:0] UV_RST_090A = 2'h0;
  localparam logic [1:0] UV_INT_090_RST_070 = 2'h1;
  localparam logic [1:0] UV_RST_070 = 2'h2;
  localparam logic [1:0] REFRESH_SIMPLE = 2'h0;
  localparam logic [1:0] REFRESH_RANDOM_1 = 2'h1;
  localparam logic [1:0] REFRESH_RANDOM_2 = 2'h2;
  localparam logic [2:0] CMDS_ONE = 3'h1;
  localparam logic [2:0] CMDS_TWO = 3'h2;
  localparam logic [2:0] CMDS_FOUR = 3'h4;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ = 50000000;
  localparam int RST_LEN_US_0 = 1000;
  localparam int RST_LEN_US_1 = 5000;
  localparam int RST_LEN_US_2 = 10000;
  localparam int RST_LEN_US_3 = 20000;
  localparam int ACT_US_0 = 200;
  localparam int ACT_US_1 = 400;
  localparam int ACT_US_2 = 800;
  localparam int ACT_US_3 = 1600;
  localparam int CYC_W = 20;

  typedef struct packed {
    logic pairSyncSense;
    logic [1:0] undervoltage_reaction_sel;
    logic [1:0] reset_pulse_length_sel;
    logic aux_regulator_voltage_sel;
    logic [1:0] cyclicActTimeSel;
  } sps_supply_t;

  typedef struct packed {
    logic irq_read_deadline_en;
    logic supply_overcurrent_mode;
    logic overcurrent_timer_sel;
    logic failsafe_output_timing;
    logic [1:0] refresh_scheme_sel;
    logic window_or_timeout_sel;
    logic crankingSel;
  } sps_watchdog_t;

  typedef struct packed {
    logic uvIntAt090;
    logic uvResetAt070;
    logic aux5v0;
    logic [CYC_W-1:0] resetHoldCycles;
    logic [CYC_W-1:0] cyclicActCycles;
  } sps_supply_ctl_t;

  typedef struct packed {
    logic randomCodeRefresh;
    logic [2:0] refreshCmdCount;
  } sps_refresh_ctl_t;

endpackage

// ### core/sps_setup_regs.sv
// Start-up configuration register bank behind a 16-bit serial frame port.
// Assumes serial pins synchronous to clk_sys, clock idle low, MSB first.
`timescale 1ns/1ps

// Behaviour
// - Both registers take writes only during the start-up configuration phase.
// - Address 0_0101 in command byte selects supply register; data in second byte.
// - Supply bit 7 picks pair sensing; resets to 0x80.
// - Supply bits 6:5 select undervoltage reset or interrupt threshold.
// - Supply bits 4:3 select reset hold of 1, 5, 10 or 20 ms.
// - Supply bit 2 selects auxiliary regulator 3.3 V or 5.0 V.
// - Supply bits 1:0 select activation time 200 to 1600 us.
// - Address 0_0110 selects watchdog setup register with its seven fields.
// - Refresh scheme: simple, or random code with one, two, four commands.
module sps_setup_regs
  import sps_pkg::*;
#(
  parameter int RST_CYC_0 = RST_LEN_US_0 * (CLK_HZ / 1000000),
  parameter int RST_CYC_1 = RST_LEN_US_1 * (CLK_HZ / 1000000),
  parameter int RST_CYC_2 = RST_LEN_US_2 * (CLK_HZ / 1000000),
  parameter int RST_CYC_3 = RST_LEN_US_3 * (CLK_HZ / 1000000),
  parameter int ACT_CYC_0 = ACT_US_0 * (CLK_HZ / 1000000),
  parameter int ACT_CYC_1 = ACT_US_1 * (CLK_HZ / 1000000),
  parameter int ACT_CYC_2 = ACT_US_2 * (CLK_HZ / 1000000),
  parameter int ACT_CYC_3 = ACT_US_3 * (CLK_HZ / 1000000)
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic initPhase,
  input wire logic sclk,
  input wire logic chipSel_b,
  input wire logic mosi,
  output logic miso,
  output logic misoOe,
  output sps_supply_t supplySetup,
  output sps_watchdog_t watchdogSetup,
  output sps_supply_ctl_t supplyCtl,
  output sps_refresh_ctl_t refreshCtl,
  output logic writeRejected
);

  // ****************************************************************
  // Serial front end
  // ****************************************************************
  logic sclkPrev_q;
  logic csPrev_b_q;
  logic [FRAME_BITS-1:0] rxShift_q;
  logic [CNT_W-1:0] bitCnt_q;
  logic [7:0] txShift_q;
  logic miso_q;
  logic sclkRise;
  logic sclkFall;
  logic frameEnd;
  logic frameOk;
  logic [1:0] cmdField;
  logic [4:0] addrField;
  logic [7:0] dataField;
  logic [4:0] rdAddr;
  logic [7:0] rdData;
  logic [7:0] supplyReg_q;
  logic [7:0] watchdogReg_q;
  logic rejected_q;

  assign sclkRise = ~chipSel_b & sclk & ~sclkPrev_q;
  assign sclkFall = ~chipSel_b & ~sclk & sclkPrev_q;
  assign frameEnd = chipSel_b & ~csPrev_b_q;
  assign frameOk = frameEnd & (bitCnt_q == CNT_FRAME);
  assign cmdField = rxShift_q[CMD_HI:CMD_LO];
  assign addrField = rxShift_q[ADDR_HI:ADDR_LO];
  assign dataField = rxShift_q[DATA_HI:0];
  // Address bits already shifted in when the eighth bit arrives
  assign rdAddr = rxShift_q[ADDR_HI-ADDR_LO:0];

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclkPrev_q <= 1'b0;
      csPrev_b_q <= 1'b1;
    end
    else
    begin
      sclkPrev_q <= sclk;
      csPrev_b_q <= chipSel_b;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rxShift_q <= '0;
      bitCnt_q <= '0;
    end
    else if (chipSel_b)
    begin
      bitCnt_q <= '0;
    end
    else if (sclkRise)
    begin
      rxShift_q <= {rxShift_q[FRAME_BITS-2:0], mosi};
      if (bitCnt_q != CNT_FRAME)
      begin
        bitCnt_q <= bitCnt_q + 5'h01;
      end
    end
  end

  // ****************************************************************
  // Read back
  // ****************************************************************
  always_comb
  begin
    case (rdAddr)
      ADDR_SUPPLY_SETUP: rdData = supplyReg_q;
      ADDR_WATCHDOG_SETUP: rdData = watchdogReg_q;
      default: rdData = '0;
    endcase
  end

  // Second byte of the frame returns the addressed register
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      txShift_q <= '0;
      miso_q <= 1'b0;
    end
    else if (chipSel_b)
    begin
      txShift_q <= '0;
      miso_q <= 1'b0;
    end
    else if (sclkRise && bitCnt_q == CNT_LAST_CMD_BIT)
    begin
      txShift_q <= rdData;
    end
    else if (sclkFall && bitCnt_q >= CNT_FIRST_DATA && bitCnt_q != CNT_FRAME)
    begin
      miso_q <= txShift_q[7];
      txShift_q <= {txShift_q[6:0], 1'b0};
    end
  end

  assign miso = miso_q;
  assign misoOe = ~chipSel_b;

  // ****************************************************************
  // Register writes
  // ****************************************************************
  // parity bit ignored, host keeps it zero
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      supplyReg_q <= SUPPLY_SETUP_RST;
    end
    else if (frameOk && initPhase && cmdField == CMD_WRITE && addrField == ADDR_SUPPLY_SETUP)
    begin
      supplyReg_q <= dataField;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      watchdogReg_q <= WATCHDOG_SETUP_RST;
    end
    else if (frameOk && initPhase && cmdField == CMD_WRITE && addrField == ADDR_WATCHDOG_SETUP)
    begin
      watchdogReg_q <= dataField;
    end
  end

  // Pulses one cycle when a write to either register is refused
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rejected_q <= 1'b0;
    end
    else
    begin
      rejected_q <= frameOk && !initPhase && cmdField == CMD_WRITE &&
        (addrField == ADDR_SUPPLY_SETUP || addrField == ADDR_WATCHDOG_SETUP);
    end
  end

  assign writeRejected = rejected_q;

  // ****************************************************************
  // Field decode
  // ****************************************************************
  // supply and watchdog fields
  assign supplySetup = sps_supply_t'(supplyReg_q);
  assign watchdogSetup = sps_watchdog_t'(watchdogReg_q);

  always_comb
  begin
    case (supplySetup.undervoltage_reaction_sel)
      UV_INT_090_RST_070:
      begin
        supplyCtl.uvIntAt090 = 1'b1;
        supplyCtl.uvResetAt070 = 1'b1;
      end
      UV_RST_070:
      begin
        supplyCtl.uvIntAt090 = 1'b0;
        supplyCtl.uvResetAt070 = 1'b1;
      end
      default:
      begin
        supplyCtl.uvIntAt090 = 1'b0;
        supplyCtl.uvResetAt070 = 1'b0;
      end
    endcase
    supplyCtl.aux5v0 = supplySetup.aux_regulator_voltage_sel;
    case (supplySetup.reset_pulse_length_sel)
      2'h0: supplyCtl.resetHoldCycles = CYC_W'(RST_CYC_0);
      2'h1: supplyCtl.resetHoldCycles = CYC_W'(RST_CYC_1);
      2'h2: supplyCtl.resetHoldCycles = CYC_W'(RST_CYC_2);
      default: supplyCtl.resetHoldCycles = CYC_W'(RST_CYC_3);
    endcase
    case (supplySetup.cyclicActTimeSel)
      2'h0: supplyCtl.cyclicActCycles = CYC_W'(ACT_CYC_0);
      2'h1: supplyCtl.cyclicActCycles = CYC_W'(ACT_CYC_1);
      2'h2: supplyCtl.cyclicActCycles = CYC_W'(ACT_CYC_2);
      default: supplyCtl.cyclicActCycles = CYC_W'(ACT_CYC_3);
    endcase
  end

  always_comb
  begin
    case (watchdogSetup.refresh_scheme_sel)
      REFRESH_SIMPLE:
      begin
        refreshCtl.randomCodeRefresh = 1'b0;
        refreshCtl.refreshCmdCount = CMDS_ONE;
      end
      REFRESH_RANDOM_1:
      begin
        refreshCtl.randomCodeRefresh = 1'b1;
        refreshCtl.refreshCmdCount = CMDS_ONE;
      end
      REFRESH_RANDOM_2:
      begin
        refreshCtl.randomCodeRefresh = 1'b1;
        refreshCtl.refreshCmdCount = CMDS_TWO;
      end
      default:
      begin
        refreshCtl.randomCodeRefresh = 1'b1;
        refreshCtl.refreshCmdCount = CMDS_FOUR;
      end
    endcase
  end

endmodule

// ### tb/sps_host_model.sv
// Host model: serial master sending 16-bit frames.
// Assumes clk_sys from the bench; serial clock idles low.
`timescale 1ns/1ps
module sps_host_model
(
  input wire logic clk_sys,
  input wire logic miso,
  output logic sclk,
  output logic chipSel_b,
  output logic mosi
);
  initial
  begin
    sclk = 1'b0;
    chipSel_b = 1'b1;
    mosi = 1'b0;
  end
  // ********
  // Frame
  // ********
  // Sends the top n bits, h clocks per half bit
  task automatic xfer(input logic [15:0] f, input int h, input int n, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clk_sys);
    chipSel_b <= 1'b0;
    for (int i = 15; i > 15 - n; i--)
    begin
      mosi <= (i == 8) ? 1'b0 : f[i];
      repeat (h) @(posedge clk_sys);
      if (i < 8)
        rd[i] = miso;
      sclk <= 1'b1;
      repeat (h) @(posedge clk_sys);
      sclk <= 1'b0;
    end
    repeat (h) @(posedge clk_sys);
    chipSel_b <= 1'b1;
    mosi <= ~mosi;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule

// ### tb/sps_setup_regs_assertions.sv
// Port checker for the setup register bank.
// Bound to the bank from the bench top.
`timescale 1ns/1ps
module sps_setup_regs_assertions
  import sps_pkg::*;
#(
  parameter int RST_CYC_0 = 10,
  parameter int RST_CYC_1 = 50,
  parameter int RST_CYC_2 = 100,
  parameter int RST_CYC_3 = 200
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic initPhase,
  input wire logic chipSel_b,
  input wire logic miso,
  input wire logic misoOe,
  input wire sps_supply_t supplySetup,
  input wire sps_watchdog_t watchdogSetup,
  input wire sps_supply_ctl_t supplyCtl,
  input wire sps_refresh_ctl_t refreshCtl,
  input wire logic writeRejected
);
  localparam int HOLD[4] = '{RST_CYC_0, RST_CYC_1, RST_CYC_2, RST_CYC_3};
  wire [1:0] uv = supplySetup.undervoltage_reaction_sel;
  wire [1:0] rf = watchdogSetup.refresh_scheme_sel;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // ********
  // Checks
  // ********
  a_rej_hold: assert property (writeRejected |-> $stable({supplySetup, watchdogSetup}))
    else $error("rejected write stored");
  a_rej_pulse: assert property (writeRejected |=> !writeRejected)
    else $error("reject flag too long");
  a_rej_cause: assert property (writeRejected |-> chipSel_b && !$past(initPhase))
    else $error("reject flag without cause");
  a_init_only: assert property (!$stable({supplySetup, watchdogSetup}) |-> $past(initPhase) && chipSel_b)
    else $error("store outside setup phase");
  a_oe_select: assert property (misoOe == !chipSel_b)
    else $error("enable not tied to select");
  a_miso_idle: assert property (chipSel_b [*3] |-> !miso)
    else $error("data out not idle");
  a_uv_decode: assert property (supplyCtl.uvIntAt090 == (uv == 2'h1)
    && supplyCtl.uvResetAt070 == (uv[1] ^ uv[0])) else $error("undervoltage decode");
  a_hold_decode: assert property (supplyCtl.resetHoldCycles
    == CYC_W'(HOLD[supplySetup.reset_pulse_length_sel])) else $error("hold decode");
  a_refresh_decode: assert property (refreshCtl.randomCodeRefresh == (rf != 2'h0)
    && (rf == 2'h0 || refreshCtl.refreshCmdCount == 3'h1 << (rf - 2'h1))) else $error("refresh decode");
  c_reject: cover property (writeRejected);
  c_store: cover property (!$stable(supplySetup));
  c_read: cover property (!chipSel_b && miso);
endmodule

// ### tb/sps_setup_regs_bench.sv
// Bench for the setup register bank.
// Assumes the package, host model and checker compiled first.
`timescale 1ns/1ps
module sps_setup_regs_bench;
  import sps_pkg::*;
  localparam int HOLD[4] = '{10, 50, 100, 200};
  localparam int ACT[4] = '{2, 4, 8, 16};
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic initPhase = 1'b1;
  logic sclk, chipSel_b, mosi, miso, misoOe, writeRejected;
  sps_supply_t supplySetup;
  sps_watchdog_t watchdogSetup;
  sps_supply_ctl_t supplyCtl;
  sps_refresh_ctl_t refreshCtl;
  int err_total = 0;
  int n_tests = 0;
  int seed = 32'h3d6ba0fd;
  int supM = 'h80;
  int wdM = 'h42;
  int rejN = 0;
  logic [7:0] rd;
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (writeRejected === 1'b1)
      rejN++;
  sps_host_model i_host (.clk_sys(clk_sys), .miso(miso), .sclk(sclk), .chipSel_b(chipSel_b), .mosi(mosi));
  sps_setup_regs #(.RST_CYC_0(HOLD[0]), .RST_CYC_1(HOLD[1]), .RST_CYC_2(HOLD[2]), .RST_CYC_3(HOLD[3]),
    .ACT_CYC_0(ACT[0]), .ACT_CYC_1(ACT[1]), .ACT_CYC_2(ACT[2]), .ACT_CYC_3(ACT[3])) i_sps_setup_regs (
    .clk_sys(clk_sys), .rst_b(rst_b), .initPhase(initPhase), .sclk(sclk), .chipSel_b(chipSel_b),
    .mosi(mosi), .miso(miso), .misoOe(misoOe), .supplySetup(supplySetup), .watchdogSetup(watchdogSetup),
    .supplyCtl(supplyCtl), .refreshCtl(refreshCtl), .writeRejected(writeRejected));
  // ********
  // Tasks
  // ********
  task automatic check(input string what, input logic [42:0] exp, input logic [42:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_regs();
    logic [1:0] u;
    u = supM[6:5];
    check("supply", supM, supplySetup);
    check("watchdog", wdM, watchdogSetup);
    check("decode", {u == 2'h1, u == 2'h1 || u == 2'h2, supM[2], 20'(HOLD[supM[4:3]]), 20'(ACT[supM[1:0]])}, supplyCtl);
    if (wdM[3:2] != 0)
      check("refresh", {1'b1, 3'h1 << (wdM[3:2] - 1)}, refreshCtl);
    else
      check("refresh", 1'b0, refreshCtl.randomCodeRefresh);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input int h);
    i_host.xfer({CMD_WRITE, a, 1'b0, d}, h, 16, rd);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ********
  // Sequence
  // ********
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check_regs();
    for (int k = 0; k < 4; k++)
    begin
      supM = $random(seed) & 'h80 | k << 5 | k << 3 | k[0] << 2 | k;
      wdM = $random(seed) & 'hf3 | k << 2;
      wr(ADDR_SUPPLY_SETUP, supM[7:0], 4 + k);
      wr(ADDR_WATCHDOG_SETUP, wdM[7:0], 4);
      check_regs();
      i_host.xfer({2'h0, ADDR_SUPPLY_SETUP, 9'h0}, 4, 16, rd);
      check("readback", supM, rd);
      i_host.xfer({2'h0, ADDR_WATCHDOG_SETUP, 9'h0}, 4, 16, rd);
      check("wd readback", wdM, rd);
    end
    for (int c = 2; c < 4; c++)
      i_host.xfer({c[1:0], ADDR_SUPPLY_SETUP, 9'h0}, 4, 16, rd);
    wr(5'h07, 8'h5a, 4);
    i_host.xfer({CMD_WRITE, ADDR_SUPPLY_SETUP, 9'h0}, 4, 15, rd);
    i_host.xfer({2'h0, 5'h07, 9'h0}, 4, 16, rd);
    check("unmapped", 0, rd);
    check_regs();
    initPhase <= 1'b0;
    wr(ADDR_SUPPLY_SETUP, ~supM[7:0], 4);
    wr(ADDR_WATCHDOG_SETUP, ~wdM[7:0], 4);
    check_regs();
    check("rejects", 2, rejN);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    initPhase <= 1'b1;
    supM = 'h80;
    wdM = 'h42;
    @(posedge clk_sys);
    check_regs();
    finish_test();
  end
  initial
  begin
    #500000;
    err_total++;
    finish_test();
  end
endmodule
bind sps_setup_regs sps_setup_regs_assertions #(.RST_CYC_0(RST_CYC_0), .RST_CYC_1(RST_CYC_1),
  .RST_CYC_2(RST_CYC_2), .RST_CYC_3(RST_CYC_3)) i_chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .initPhase(initPhase), .chipSel_b(chipSel_b), .miso(miso), .misoOe(misoOe), .supplySetup(supplySetup),
  .watchdogSetup(watchdogSetup), .supplyCtl(supplyCtl), .refreshCtl(refreshCtl), .writeRejected(writeRejected));
